// ### data_memory_space_pkg.sv
// constants and types shared by the data memory space decoder and its
// external bus sequencer; assumes a 125 MHz core clock
package data_memory_space_pkg;

  // clock rate used to turn times into cycle counts
  localparam int CLK_MHZ = 125;

  // internal data memory layout
  localparam int IRAM_DEPTH = 256;
  localparam int XRAM_DEPTH = 256; // 768 on the larger variant
  localparam logic [7:0] LOWER_RAM_TOP = 8'h7F;
  localparam logic [15:0] XRAM_LAST = 16'(XRAM_DEPTH - 1);

  // values after reset
  localparam logic [7:0] RDATA_RST = 8'h00;
  localparam logic [15:0] ADDR_RST = 16'h0000;
  localparam logic [7:0] CNT_RST = 8'h00;

  // external bus phase times in ns
  localparam int ALE_NS = 115;
  localparam int ADDR_HOLD_NS = 40;
  localparam int STROBE_NS = 350;
  localparam int DATA_HOLD_NS = 43;

  // least times round up to whole cycles
  localparam logic [7:0] ALE_CYC =
    8'((ALE_NS * CLK_MHZ + 999) / 1000);
  localparam logic [7:0] ADDR_HOLD_CYC =
    8'((ADDR_HOLD_NS * CLK_MHZ + 999) / 1000);
  localparam logic [7:0] STROBE_CYC =
    8'((STROBE_NS * CLK_MHZ + 999) / 1000);
  localparam logic [7:0] DATA_HOLD_CYC =
    8'((DATA_HOLD_NS * CLK_MHZ + 999) / 1000);

  // how the core addresses an access
  typedef enum logic [2:0] {
    MODE_DIRECT    = 3'h0,
    MODE_INDIRECT  = 3'h1,
    MODE_STACK     = 3'h2,
    MODE_XMOVE_PTR = 3'h3,
    MODE_XMOVE_DP  = 3'h4
  } access_mode_t;

  // where an access lands
  typedef enum logic [1:0] {
    TGT_IRAM = 2'h0,
    TGT_SFR  = 2'h1,
    TGT_XRAM = 2'h2,
    TGT_EXT  = 2'h3
  } target_t;

endpackage

// ### ext_bus_sequencer.sv
// external data bus cycle: address on port zero with ale, then the read
// or write strobe; assumes port_zero_i is an asynchronous pin
`timescale 1ns/100ps
module ext_bus_sequencer
  import data_memory_space_pkg::*;
(
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // request from the decoder
  input wire logic start_i,
  input wire logic write_i,
  input wire logic wide_i,
  input wire logic [15:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic [7:0] p2_sfr_i,
  output logic done_o,
  output logic [7:0] rdata_o,
  // pins
  input wire logic [7:0] port_zero_i,
  output logic [7:0] port_zero_o,
  output logic port_zero_oe_n_o,
  output logic [7:0] port_two_o,
  output logic ale_o,
  output logic write_strobe_n_o,
  output logic read_strobe_n_o
);

  typedef enum logic [4:0] {
    BS_IDLE  = 5'b00001,
    BS_ALE   = 5'b00010,
    BS_AHOLD = 5'b00100,
    BS_STRB  = 5'b01000,
    BS_DHOLD = 5'b10000
  } bus_state_t;

  bus_state_t state_r, state_nxt;
  logic [7:0] cnt_r, cnt_nxt;
  logic [7:0] sync1_r, sync2_r;
  logic done_r, done_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  logic [7:0] p0_r, p0_nxt;
  logic p0_oe_n_r, p0_oe_n_nxt;
  logic [7:0] p2_r, p2_nxt;
  logic ale_r, ale_nxt;
  logic wr_n_r, wr_n_nxt;
  logic rd_n_r, rd_n_nxt;

  // pin synchroniser, only the second stage is read
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      sync1_r <= RDATA_RST;
      sync2_r <= RDATA_RST;
    end
    else
    begin
      sync1_r <= port_zero_i;
      sync2_r <= sync1_r;
    end
  end

  // phase sequencing and pin values
  always_comb
  begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    done_nxt = 1'b0;
    rdata_nxt = rdata_r;
    p0_nxt = p0_r;
    p0_oe_n_nxt = p0_oe_n_r;
    p2_nxt = p2_r;
    ale_nxt = ale_r;
    wr_n_nxt = wr_n_r;
    rd_n_nxt = rd_n_r;
    unique case (state_r)
      BS_IDLE:
      begin
        p2_nxt = p2_sfr_i; // port two follows its register when idle
        p0_oe_n_nxt = 1'b1;
        if (start_i)
        begin
          state_nxt = BS_ALE;
          cnt_nxt = ALE_CYC;
          ale_nxt = 1'b1;
          p0_nxt = addr_i[7:0]; // R11 R12
          p0_oe_n_nxt = 1'b0;
          p2_nxt = wide_i ? addr_i[15:8] : p2_sfr_i; // R12 R11
        end
      end
      BS_ALE:
      begin
        cnt_nxt = cnt_r - 8'h01;
        if (cnt_r == 8'h01)
        begin
          state_nxt = BS_AHOLD;
          cnt_nxt = ADDR_HOLD_CYC;
          ale_nxt = 1'b0;
        end
      end
      BS_AHOLD:
      begin
        cnt_nxt = cnt_r - 8'h01;
        if (cnt_r == 8'h01)
        begin
          state_nxt = BS_STRB;
          cnt_nxt = STROBE_CYC;
          // address then data share port zero
          p0_nxt = wdata_i;
          p0_oe_n_nxt = !write_i;
          wr_n_nxt = !write_i; // R13
          rd_n_nxt = write_i; // R13
        end
      end
      BS_STRB:
      begin
        cnt_nxt = cnt_r - 8'h01;
        if (cnt_r == 8'h01)
        begin
          state_nxt = BS_DHOLD;
          cnt_nxt = DATA_HOLD_CYC;
          rdata_nxt = sync2_r; // strobe is long, sync lag is harmless
          wr_n_nxt = 1'b1;
          rd_n_nxt = 1'b1;
        end
      end
      BS_DHOLD:
      begin
        cnt_nxt = cnt_r - 8'h01;
        if (cnt_r == 8'h01)
        begin
          state_nxt = BS_IDLE;
          cnt_nxt = CNT_RST;
          p0_oe_n_nxt = 1'b1;
          done_nxt = 1'b1;
        end
      end
      default:
      begin
        state_nxt = BS_IDLE;
        cnt_nxt = CNT_RST;
      end
    endcase
  end

  // state registers
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      state_r <= BS_IDLE;
      cnt_r <= CNT_RST;
      done_r <= 1'b0;
      rdata_r <= RDATA_RST;
      p0_r <= RDATA_RST;
      p0_oe_n_r <= 1'b1;
      p2_r <= RDATA_RST;
      ale_r <= 1'b0;
      wr_n_r <= 1'b1;
      rd_n_r <= 1'b1;
    end
    else
    begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      done_r <= done_nxt;
      rdata_r <= rdata_nxt;
      p0_r <= p0_nxt;
      p0_oe_n_r <= p0_oe_n_nxt;
      p2_r <= p2_nxt;
      ale_r <= ale_nxt;
      wr_n_r <= wr_n_nxt;
      rd_n_r <= rd_n_nxt;
    end
  end

  assign done_o = done_r;
  assign rdata_o = rdata_r;
  assign port_zero_o = p0_r;
  assign port_zero_oe_n_o = p0_oe_n_r;
  assign port_two_o = p2_r;
  assign ale_o = ale_r;
  assign write_strobe_n_o = wr_n_r;
  assign read_strobe_n_o = rd_n_r;

endmodule

// ### data_memory_space_decoder.sv
// data memory space decoder: internal ram, special function registers,
// on-chip expanded ram and external data bus; assumes the core holds a
// request stable until it is taken and the sfr block answers at once
`timescale 1ns/100ps

// Contract
// R01: lower ram 00h..7Fh is reached by both direct and indirect modes.
// R02: upper ram 80h..FFh is reached only by indirect modes.
// R03: special function registers at 80h..FFh are reached only directly.
// R04: a direct access above 7Fh goes to sfr space, upper ram untouched.
// R05: an indirect access above 7Fh goes to the upper ram byte.
// R06: an on-chip expanded ram sits at the bottom of external data space.
// R07: with the disable bit low, external moves in range use expanded ram.
// R08: expanded ram accesses leave port zero and both strobes idle.
// R09: port two keeps showing its register during expanded ram accesses.
// R10: pointer-pair moves above the expanded ram run an external cycle.
// R11: with the disable bit high, pointer moves put 8 address bits out.
// R12: with the disable bit high, pointer-pair moves put 16 bits out.
// R13: off-chip moves pulse write strobe for writes, read for reads.
// R14: stack accesses reach only the 256 byte internal ram.
// R15: with the disable bit high no external move uses expanded ram.
module data_memory_space_decoder
  import data_memory_space_pkg::*;
(
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // core access request
  input wire logic acc_valid_i,
  output logic acc_ready_o,
  input wire logic acc_write_i,
  input wire data_memory_space_pkg::access_mode_t acc_mode_i,
  input wire logic [15:0] acc_addr_i,
  input wire logic [7:0] acc_wdata_i,
  output logic acc_done_o,
  output logic [7:0] acc_rdata_o,
  // configuration
  input wire logic on_chip_xram_disable_i,
  // special function register side
  output logic sfr_sel_o,
  output logic sfr_write_o,
  output logic [7:0] sfr_addr_o,
  output logic [7:0] sfr_wdata_o,
  input wire logic [7:0] sfr_rdata_i,
  input wire logic [7:0] port_two_sfr_i,
  // external bus pins
  input wire logic [7:0] port_zero_i,
  output logic [7:0] port_zero_o,
  output logic port_zero_oe_n_o,
  output logic [7:0] port_two_o,
  output logic ale_o,
  output logic write_strobe_n_o,
  output logic read_strobe_n_o
);
  import data_memory_space_pkg::*;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_MEM  = 4'b0010,
    ST_SFR  = 4'b0100,
    ST_EXT  = 4'b1000
  } dec_state_t;

  // where an access lands, from mode, address and disable bit
  function automatic target_t decode_target(
    input access_mode_t mode,
    input logic [15:0] addr,
    input logic xdis
  );
    target_t tgt;
    tgt = TGT_IRAM;
    unique case (mode)
      MODE_DIRECT:
        tgt = (addr[7:0] > LOWER_RAM_TOP) ? TGT_SFR : TGT_IRAM; // R01 R04
      MODE_INDIRECT:
        tgt = TGT_IRAM; // R01 R02 R05
      MODE_STACK:
        tgt = TGT_IRAM; // R14
      MODE_XMOVE_PTR:
        tgt = xdis ? TGT_EXT : TGT_XRAM; // R07 R11 R15
      MODE_XMOVE_DP:
        tgt = (!xdis && addr <= XRAM_LAST) ? TGT_XRAM : TGT_EXT; // R10 R15
      default:
        tgt = TGT_IRAM;
    endcase
    return tgt;
  endfunction

  // lower and upper ram share one array, sfr space lives outside
  logic [7:0] iram_mem [IRAM_DEPTH];
  // on-chip expanded ram
  logic [7:0] xram_mem [XRAM_DEPTH];

  dec_state_t state_r, state_nxt;
  target_t tgt_r, tgt_nxt;
  logic [15:0] addr_r, addr_nxt;
  logic [7:0] wdata_r, wdata_nxt;
  logic write_r, write_nxt;
  logic wide_r, wide_nxt;
  logic done_r, done_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  logic start_r, start_nxt;
  logic iram_we, xram_we;
  logic ext_done;
  logic [7:0] ext_rdata;
  target_t req_tgt;

  assign req_tgt = decode_target(acc_mode_i, acc_addr_i,
                                 on_chip_xram_disable_i);
  // take a request only when idle
  assign acc_ready_o = (state_r == ST_IDLE);

  // request capture, memory access and completion
  always_comb
  begin
    state_nxt = state_r;
    tgt_nxt = tgt_r;
    addr_nxt = addr_r;
    wdata_nxt = wdata_r;
    write_nxt = write_r;
    wide_nxt = wide_r;
    done_nxt = 1'b0;
    rdata_nxt = rdata_r;
    start_nxt = 1'b0;
    iram_we = 1'b0;
    xram_we = 1'b0;
    unique case (state_r)
      ST_IDLE:
      begin
        if (acc_valid_i)
        begin
          tgt_nxt = req_tgt;
          // pointer moves carry only an 8-bit address
          addr_nxt = (acc_mode_i == MODE_DIRECT ||
                      acc_mode_i == MODE_XMOVE_DP) ?
                     acc_addr_i : {8'h00, acc_addr_i[7:0]};
          wdata_nxt = acc_wdata_i;
          write_nxt = acc_write_i;
          wide_nxt = (acc_mode_i == MODE_XMOVE_DP); // R12
          unique case (req_tgt)
            TGT_SFR: state_nxt = ST_SFR; // R03
            TGT_EXT:
            begin
              state_nxt = ST_EXT;
              start_nxt = 1'b1; // R10 R11 R12
            end
            default: state_nxt = ST_MEM;
          endcase
        end
      end
      ST_MEM:
      begin
        // expanded ram never touches the bus sequencer
        if (tgt_r == TGT_XRAM)
        begin
          xram_we = write_r; // R06 R07 R08 R09
          rdata_nxt = xram_mem[addr_r[7:0]];
        end
        else
        begin
          iram_we = write_r; // R02 R05 R14
          rdata_nxt = iram_mem[addr_r[7:0]];
        end
        done_nxt = 1'b1;
        state_nxt = ST_IDLE;
      end
      ST_SFR:
      begin
        rdata_nxt = sfr_rdata_i; // R04
        done_nxt = 1'b1;
        state_nxt = ST_IDLE;
      end
      ST_EXT:
      begin
        if (ext_done)
        begin
          rdata_nxt = ext_rdata;
          done_nxt = 1'b1;
          state_nxt = ST_IDLE;
        end
      end
      default:
        state_nxt = ST_IDLE;
    endcase
  end

  // control registers
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      state_r <= ST_IDLE;
      tgt_r <= TGT_IRAM;
      addr_r <= ADDR_RST;
      wdata_r <= RDATA_RST;
      write_r <= 1'b0;
      wide_r <= 1'b0;
      done_r <= 1'b0;
      rdata_r <= RDATA_RST;
      start_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      tgt_r <= tgt_nxt;
      addr_r <= addr_nxt;
      wdata_r <= wdata_nxt;
      write_r <= write_nxt;
      wide_r <= wide_nxt;
      done_r <= done_nxt;
      rdata_r <= rdata_nxt;
      start_r <= start_nxt;
    end
  end

  // memory arrays have no reset, contents are undefined at power-up
  always_ff @(posedge clk_sys_i)
  begin
    if (iram_we)
      iram_mem[addr_r[7:0]] <= wdata_r;
    if (xram_we)
      xram_mem[addr_r[7:0]] <= wdata_r;
  end

  // sfr strobe lasts the one cycle of the sfr state
  assign sfr_sel_o = (state_r == ST_SFR);
  assign sfr_write_o = (state_r == ST_SFR) && write_r;
  assign sfr_addr_o = addr_r[7:0];
  assign sfr_wdata_o = wdata_r;

  assign acc_done_o = done_r;
  assign acc_rdata_o = rdata_r;

  // off-chip cycles only; port two shows its register otherwise
  ext_bus_sequencer u_ext_bus (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .start_i(start_r),
    .write_i(write_r),
    .wide_i(wide_r),
    .addr_i(addr_r),
    .wdata_i(wdata_r),
    .p2_sfr_i(port_two_sfr_i),
    .done_o(ext_done),
    .rdata_o(ext_rdata),
    .port_zero_i(port_zero_i),
    .port_zero_o(port_zero_o),
    .port_zero_oe_n_o(port_zero_oe_n_o),
    .port_two_o(port_two_o),
    .ale_o(ale_o),
    .write_strobe_n_o(write_strobe_n_o),
    .read_strobe_n_o(read_strobe_n_o)
  );

endmodule

// ### data_memory_space_props.sv
// assertions on the data memory space decoder ports
// assumes one clock domain and the access mode encoding of the package
`timescale 1ns/100ps
module data_memory_space_props (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // core side
  input wire logic acc_valid_i,
  input wire logic acc_ready_o,
  input wire logic acc_write_i,
  input wire data_memory_space_pkg::access_mode_t acc_mode_i,
  input wire logic [15:0] acc_addr_i,
  input wire logic acc_done_o,
  input wire logic on_chip_xram_disable_i,
  // sfr side and pins
  input wire logic sfr_sel_o,
  input wire logic sfr_write_o,
  input wire logic [7:0] sfr_addr_o,
  input wire logic [7:0] port_two_sfr_i,
  input wire logic [7:0] port_zero_o,
  input wire logic port_zero_oe_n_o,
  input wire logic [7:0] port_two_o,
  input wire logic ale_o,
  input wire logic write_strobe_n_o,
  input wire logic read_strobe_n_o
);
  import data_memory_space_pkg::*;
  logic take, xram_hit, ext_hit, sfr_hit, is_x;
  logic [7:0] low_cnt_r;
  logic [7:0] low_cnt_nxt;
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);

  // decode of a request at the edge that takes it
  assign take = acc_valid_i && acc_ready_o;
  assign is_x = acc_mode_i == MODE_XMOVE_PTR || acc_mode_i == MODE_XMOVE_DP;
  assign xram_hit = take && is_x && !on_chip_xram_disable_i &&
    (acc_mode_i == MODE_XMOVE_PTR || acc_addr_i <= XRAM_LAST);
  assign ext_hit = take && is_x && !xram_hit;
  assign sfr_hit = take && acc_mode_i == MODE_DIRECT &&
    acc_addr_i[7:0] > LOWER_RAM_TOP;

  // strobe low time, counted so its exact length can be checked
  always_comb
  begin
    low_cnt_nxt = low_cnt_r + 8'h01;
    if (write_strobe_n_o && read_strobe_n_o)
      low_cnt_nxt = CNT_RST;
  end
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      low_cnt_r <= CNT_RST;
    else
      low_cnt_r <= low_cnt_nxt;
  end

  sequence pins_idle;
    write_strobe_n_o && read_strobe_n_o && !ale_o && port_zero_oe_n_o;
  endsequence
  sequence ext_start;
    ##2 ale_o && !port_zero_oe_n_o;
  endsequence

  a_sfr_direct: assert property (
    sfr_hit |=> sfr_sel_o && sfr_addr_o == $past(acc_addr_i[7:0]) &&
    sfr_write_o == $past(acc_write_i))
    else $error("direct access above lower ram missed sfr space");
  a_no_sfr_else: assert property (
    take && !sfr_hit |=> !sfr_sel_o)
    else $error("sfr selected by a non-direct access");
  a_xram_quiet: assert property (
    xram_hit |=> (pins_idle) [*2])
    else $error("expanded ram access moved bus pins");
  a_xram_port_two: assert property (
    xram_hit |=> port_two_o == $past(port_two_sfr_i))
    else $error("port two not showing its register");
  a_ext_start: assert property (
    ext_hit |-> ext_start)
    else $error("off-chip move did not open a bus cycle");
  a_dp_addr: assert property (
    ext_hit && acc_mode_i == MODE_XMOVE_DP |-> ##2
    port_two_o == $past(acc_addr_i[15:8], 2) &&
    port_zero_o == $past(acc_addr_i[7:0], 2))
    else $error("pointer pair address wrong on ports");
  a_strobe_len: assert property (
    $rose(write_strobe_n_o) || $rose(read_strobe_n_o) |->
    low_cnt_r == STROBE_CYC)
    else $error("strobe width wrong");
  a_strobe_data: assert property (
    !write_strobe_n_o |-> !port_zero_oe_n_o && read_strobe_n_o)
    else $error("write strobe without driven data");
  a_int_done: assert property (
    take && !ext_hit |-> ##2 acc_done_o)
    else $error("on-chip access not done in two cycles");
endmodule

bind data_memory_space_decoder data_memory_space_props u_props (
  .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
  .acc_valid_i(acc_valid_i), .acc_ready_o(acc_ready_o),
  .acc_write_i(acc_write_i), .acc_mode_i(acc_mode_i),
  .acc_addr_i(acc_addr_i), .acc_done_o(acc_done_o),
  .on_chip_xram_disable_i(on_chip_xram_disable_i),
  .sfr_sel_o(sfr_sel_o), .sfr_write_o(sfr_write_o),
  .sfr_addr_o(sfr_addr_o), .port_two_sfr_i(port_two_sfr_i),
  .port_zero_o(port_zero_o), .port_zero_oe_n_o(port_zero_oe_n_o),
  .port_two_o(port_two_o), .ale_o(ale_o),
  .write_strobe_n_o(write_strobe_n_o),
  .read_strobe_n_o(read_strobe_n_o)
);

// ### ext_data_mem.sv
// behavioural external data memory on the multiplexed port zero bus
// assumes the bench resolves the pin level from the output enable
`timescale 1ns/100ps
module ext_data_mem (
  // bus from the decoder
  input wire logic ale_i,
  input wire logic [7:0] p0_i,
  input wire logic [7:0] p2_i,
  input wire logic p0_oe_n_i,
  input wire logic wr_n_i,
  input wire logic rd_n_i,
  // data driven back during reads
  output logic [7:0] p0_o
);
  logic [7:0] store [logic [15:0]];
  logic [15:0] addr_q;
  int delay_ns = 20;
  int cycles = 0;
  initial p0_o = 8'h3C;
  // latch the full address as ale falls; enable check skips reset edges
  always @(negedge ale_i)
    if (p0_oe_n_i === 1'b0)
    begin
      addr_q = {p2_i, p0_i};
      cycles++;
    end
  // capture write data as the strobe rises
  always @(posedge wr_n_i)
    if (p0_oe_n_i === 1'b0)
      store[addr_q] = p0_i;
  // answer a read after the access delay, slow or prompt
  always @(negedge rd_n_i)
    p0_o <= #(delay_ns) store[addr_q];
  // no pull-up: a released bus shows the inverse, never the old value
  always @(posedge rd_n_i)
    p0_o <= ~p0_o;
endmodule

// ### test_data_memory_space_decoder.sv
// self-checking bench for the data memory space decoder
// assumes the external memory model and the bound checker
`timescale 1ns/100ps
module test_data_memory_space_decoder;
  import data_memory_space_pkg::*;
  logic clk_sys_i, rst_n_i, acc_valid_i, acc_write_i;
  logic on_chip_xram_disable_i, acc_ready_o, acc_done_o;
  logic sfr_sel_o, sfr_write_o, port_zero_oe_n_o, ale_o;
  logic write_strobe_n_o, read_strobe_n_o;
  access_mode_t acc_mode_i;
  logic [15:0] acc_addr_i;
  logic [7:0] acc_wdata_i, acc_rdata_o, sfr_addr_o, sfr_wdata_o;
  logic [7:0] sfr_rdata_i, port_two_sfr_i, port_zero_i, port_zero_o;
  logic [7:0] port_two_o, mem_p0, q;
  int mismatches, total_checks;

  data_memory_space_decoder dut (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
    .acc_valid_i(acc_valid_i), .acc_ready_o(acc_ready_o),
    .acc_write_i(acc_write_i), .acc_mode_i(acc_mode_i),
    .acc_addr_i(acc_addr_i), .acc_wdata_i(acc_wdata_i),
    .acc_done_o(acc_done_o), .acc_rdata_o(acc_rdata_o),
    .on_chip_xram_disable_i(on_chip_xram_disable_i),
    .sfr_sel_o(sfr_sel_o), .sfr_write_o(sfr_write_o),
    .sfr_addr_o(sfr_addr_o), .sfr_wdata_o(sfr_wdata_o),
    .sfr_rdata_i(sfr_rdata_i), .port_two_sfr_i(port_two_sfr_i),
    .port_zero_i(port_zero_i), .port_zero_o(port_zero_o),
    .port_zero_oe_n_o(port_zero_oe_n_o), .port_two_o(port_two_o),
    .ale_o(ale_o), .write_strobe_n_o(write_strobe_n_o),
    .read_strobe_n_o(read_strobe_n_o));
  ext_data_mem ext (.ale_i(ale_o), .p0_i(port_zero_i), .p2_i(port_two_o),
    .p0_oe_n_i(port_zero_oe_n_o), .wr_n_i(write_strobe_n_o),
    .rd_n_i(read_strobe_n_o), .p0_o(mem_p0));
  // pin level: the decoder wins while it drives, else the memory
  assign port_zero_i = port_zero_oe_n_o ? mem_p0 : port_zero_o;

  initial
  begin
    clk_sys_i = 1'b0;
    forever #4 clk_sys_i = ~clk_sys_i;
  end

  task automatic check(input string what, input logic [7:0] seen,
      input logic [7:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic give_verdict;
    if (mismatches == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // one access; the decoder is idle whenever this is entered
  task automatic acc(input access_mode_t m, input logic w, input logic xd,
      input logic [15:0] a, input logic [7:0] d);
    int n;
    @(posedge clk_sys_i);
    acc_valid_i <= 1'b1;
    acc_mode_i <= m;
    acc_write_i <= w;
    on_chip_xram_disable_i <= xd;
    acc_addr_i <= a;
    acc_wdata_i <= d;
    @(posedge clk_sys_i);
    acc_valid_i <= 1'b0;
    for (n = 0; n < 200 && acc_done_o !== 1'b1; n++)
      @(negedge clk_sys_i);
    check("done", 8'(acc_done_o), 8'h01);
    q = acc_rdata_o;
  endtask

  // lower ram shared by both modes, up to its top byte
  task automatic t_lower;
    acc(MODE_DIRECT, 1'b1, 1'b0, 16'h0010, 8'h21);
    acc(MODE_INDIRECT, 1'b0, 1'b0, 16'h0010, 8'h00);
    check("lower 10", q, 8'h21);
    acc(MODE_INDIRECT, 1'b1, 1'b0, 16'h007F, 8'h42);
    acc(MODE_DIRECT, 1'b0, 1'b0, 16'h007F, 8'h00);
    check("lower 7F", q, 8'h42);
  endtask

  // same address, two spaces chosen by the mode
  task automatic t_upper;
    acc(MODE_INDIRECT, 1'b1, 1'b0, 16'h0080, 8'h5A);
    acc(MODE_DIRECT, 1'b1, 1'b0, 16'h0080, 8'hC3);
    check("sfr wdata", sfr_wdata_o, 8'hC3);
    acc(MODE_INDIRECT, 1'b0, 1'b0, 16'h0080, 8'h00);
    check("upper 80", q, 8'h5A);
    acc(MODE_DIRECT, 1'b0, 1'b0, 16'h00FF, 8'h00);
    check("sfr FF", q, 8'hE7);
  endtask

  // stack and expanded ram at one low address stay apart
  task automatic t_stack_xram;
    acc(MODE_STACK, 1'b1, 1'b0, 16'h00A1, 8'h71);
    acc(MODE_XMOVE_PTR, 1'b1, 1'b0, 16'h00A1, 8'h99);
    acc(MODE_XMOVE_DP, 1'b1, 1'b0, 16'h00FF, 8'h66);
    acc(MODE_INDIRECT, 1'b0, 1'b0, 16'h00A1, 8'h00);
    check("stack A1", q, 8'h71);
    acc(MODE_XMOVE_DP, 1'b0, 1'b0, 16'h00A1, 8'h00);
    check("xram A1", q, 8'h99);
    acc(MODE_XMOVE_PTR, 1'b0, 1'b0, 16'h00FF, 8'h00);
    check("xram FF", q, 8'h66);
    check("bus idle", 8'(ext.cycles), 8'h00);
  endtask

  // off-chip moves, with a slow memory for the read
  task automatic t_external;
    acc(MODE_XMOVE_DP, 1'b1, 1'b0, 16'h1234, 8'h96);
    check("ext 1234", ext.store[16'h1234], 8'h96);
    ext.delay_ns = 250;
    acc(MODE_XMOVE_DP, 1'b0, 1'b0, 16'h1234, 8'h00);
    check("ext rd 1234", q, 8'h96);
    acc(MODE_XMOVE_PTR, 1'b1, 1'b1, 16'h0044, 8'h2B);
    check("ext 7E44", ext.store[16'h7E44], 8'h2B);
    acc(MODE_XMOVE_DP, 1'b1, 1'b1, 16'h00A1, 8'h3D);
    check("ext 00A1", ext.store[16'h00A1], 8'h3D);
    acc(MODE_XMOVE_DP, 1'b0, 1'b0, 16'h00A1, 8'h00);
    check("xram kept", q, 8'h99);
    check("bus cycles", 8'(ext.cycles), 8'h04);
  endtask

  // watchdog, far above the few hundred cycles the tests need
  initial
  begin
    #200000;
    mismatches++;
    give_verdict;
  end

  initial
  begin
    rst_n_i = 1'b0;
    acc_valid_i = 1'b0;
    acc_write_i = 1'b0;
    acc_mode_i = MODE_DIRECT;
    acc_addr_i = 16'h0000;
    acc_wdata_i = 8'h00;
    on_chip_xram_disable_i = 1'b0;
    sfr_rdata_i = 8'hE7;
    port_two_sfr_i = 8'h7E;
    repeat (12) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    t_lower;
    t_upper;
    t_stack_xram;
    t_external;
    give_verdict;
  end
endmodule
